// >>> src/sfm_regs.svh
`ifndef SFM_REGS_SVH
`define SFM_REGS_SVH
// Notes on behaviour
// RL1: Condition-field move is primary 31, extended 144; fields at 6-10,12-19,31.
// RL2: Each set condition mask bit copies its source nibble into that field.
// RL3: Condition fields with a clear mask bit keep their old value.
// RL4: Condition-field move never touches the fixed-point exception register.
// RL5: Software should set one condition mask bit; several remain legal.
// RL6: Status bit clear is primary 63, extended 70; index 6-10, record 31.
// RL7: Status bit clear forces the indexed status bit to zero.
// RL8: Status bit set is primary 63, extended 38; index 6-10, record 31.
// RL9: Status bit set forces the indexed status bit to one.
// RL10: Status bits 1 and 2 ignore single-bit set and clear.
// RL11: Record bit copies summary, enabled, invalid and overflow into field 1.
// RL12: Single-bit status set and clear never touch the exception register.
// RL13: Status field move is primary 63, extended 771; mask 7-14, source 16-20.
// RL14: Status field move uses only the low word of the source register.
// RL15: Each set status mask bit loads one status nibble from the low word.

// Instruction word positions, big-endian numbering converted to [31:0]
`define SFM_PRIMARY_HI 31
`define SFM_PRIMARY_LO 26
`define SFM_EXT_HI 10
`define SFM_EXT_LO 1
`define SFM_RECORD_POS 0
`define SFM_REG_HI 25
`define SFM_REG_LO 21
`define SFM_CMASK_HI 19
`define SFM_CMASK_LO 12
`define SFM_FMASK_HI 24
`define SFM_FMASK_LO 17
`define SFM_FSRC_HI 15
`define SFM_FSRC_LO 11

// Opcodes
`define SFM_OP_FIXED 6'h1f
`define SFM_OP_FLOAT 6'h3f
`define SFM_XO_CRF 10'h090
`define SFM_XO_CLR 10'h046
`define SFM_XO_SET 10'h026
`define SFM_XO_FSF 10'h303

// Protected status bits, big-endian numbers
`define SFM_FP_LOCK_A 5'h01
`define SFM_FP_LOCK_B 5'h02

// Status bits copied on record, big-endian numbers
`define SFM_FP_FX 0
`define SFM_FP_FEX 1
`define SFM_FP_VX 2
`define SFM_FP_OX 3
`define SFM_CR_FIELD1 1

// Reset values
`define SFM_CR_RST 32'h0000_0000
`define SFM_FP_RST 32'h0000_0000

// AHB-Lite register map
`define SFM_A_INSN 8'h00
`define SFM_A_GPR 8'h04
`define SFM_A_FPR_LO 8'h08
`define SFM_A_FPR_HI 8'h0c
`define SFM_A_CR 8'h10
`define SFM_A_FP_STATUS_CONTROL_REGISTER 8'h14
`define SFM_A_STAT 8'h18
`define SFM_A_MASK 8'h1c
`define SFM_A_CNT 8'h20

// Status and mask bit positions
`define SFM_EV_CRF 0
`define SFM_EV_FPS 1
`define SFM_EV_BAD 2
`define SFM_EV_LOCK 3
`define SFM_NEV 4

`endif

// >>> src/sfm_pkg.sv
package sfm_pkg;

  typedef enum logic [2:0] {
    SFM_NONE = 3'b000,
    SFM_CRF = 3'b001,
    SFM_CLR = 3'b010,
    SFM_SET = 3'b011,
    SFM_FSF = 3'b100
  } sfm_op_e;

  typedef struct packed {
    sfm_op_e op;
    logic [4:0] reg_idx;
    logic [7:0] cond_field_mask;
    logic [7:0] fp_field_mask;
    logic [4:0] source_fpr;
    logic record_bit;
  } sfm_dec_s;

  typedef struct packed {
    logic [31:0] condition_register;
    logic [31:0] fp_status_control_register;
  } sfm_arch_s;

endpackage

// >>> src/sfm_decode.sv
`timescale 1ns/1ps
`include "sfm_regs.svh"

module sfm_decode (
  input wire logic [31:0] insn,
  output sfm_pkg::sfm_dec_s dec
);

  logic [5:0] primary;
  logic [9:0] ext;

  assign primary = insn[`SFM_PRIMARY_HI:`SFM_PRIMARY_LO];
  assign ext = insn[`SFM_EXT_HI:`SFM_EXT_LO];

  always_comb
  begin
    dec.reg_idx = insn[`SFM_REG_HI:`SFM_REG_LO]; // RL1 RL6 RL8
    dec.cond_field_mask = insn[`SFM_CMASK_HI:`SFM_CMASK_LO]; // RL1
    dec.fp_field_mask = insn[`SFM_FMASK_HI:`SFM_FMASK_LO]; // RL13
    dec.source_fpr = insn[`SFM_FSRC_HI:`SFM_FSRC_LO]; // RL13
    dec.record_bit = insn[`SFM_RECORD_POS]; // RL1 RL6 RL8 RL13
    dec.op = sfm_pkg::SFM_NONE;
    if (primary == `SFM_OP_FIXED && ext == `SFM_XO_CRF)
    begin
      dec.op = sfm_pkg::SFM_CRF; // RL1
    end
    else if (primary == `SFM_OP_FLOAT && ext == `SFM_XO_CLR)
    begin
      dec.op = sfm_pkg::SFM_CLR; // RL6
    end
    else if (primary == `SFM_OP_FLOAT && ext == `SFM_XO_SET)
    begin
      dec.op = sfm_pkg::SFM_SET; // RL8
    end
    else if (primary == `SFM_OP_FLOAT && ext == `SFM_XO_FSF)
    begin
      dec.op = sfm_pkg::SFM_FSF; // RL13
    end
  end

endmodule // sfm_decode

// >>> src/sfm_unit.sv
`timescale 1ns/1ps
`include "sfm_regs.svh"

module sfm_unit (
  input wire logic clock,
  input wire logic rst,
  input wire logic issue_valid,
  input wire logic [31:0] issue_insn,
  input wire logic [31:0] issue_gpr,
  input wire logic [63:0] issue_fpr,
  output logic issue_ready,
  output logic done,
  output sfm_pkg::sfm_arch_s arch,
  output logic irq,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  // ***********************************************
  // Helpers
  // ***********************************************

  // Big-endian bit n of a 32-bit word maps to [31-n]
  function automatic logic [4:0] be_pos(input logic [4:0] n);
    be_pos = 5'd31 - n;
  endfunction

  // Nibble-masked merge; mask bit 7 is the leftmost nibble
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [7:0] m);
    logic [31:0] wm;
    wm = '0;
    for (int i = 0; i < 8; i++)
    begin
      wm[i*4 +: 4] = {4{m[i]}};
    end
    merge = (new_v & wm) | (old_v & ~wm);
  endfunction

  // ***********************************************
  // Bus slave
  // ***********************************************

  logic ap_wr_r;
  logic [7:0] ap_addr_r;
  logic bus_issue;
  logic [31:0] insn_r;
  logic [31:0] gpr_r;
  logic [63:0] fpr_r;
  logic [`SFM_NEV-1:0] stat_r;
  logic [`SFM_NEV-1:0] mask_r;
  logic [31:0] cnt_r;
  logic [31:0] cr_r;
  logic [31:0] fp_r;

  wire ap_take = hsel && hready && htrans[1];

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ap_wr_r <= 1'b0;
      ap_addr_r <= 8'h00;
    end
    else if (hready)
    begin
      ap_wr_r <= ap_take && hwrite;
      ap_addr_r <= haddr[7:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (ap_take && !hwrite)
    begin
      if (haddr[7:0] == `SFM_A_INSN)
        hrdata <= insn_r;
      else if (haddr[7:0] == `SFM_A_GPR)
        hrdata <= gpr_r;
      else if (haddr[7:0] == `SFM_A_FPR_LO)
        hrdata <= fpr_r[31:0];
      else if (haddr[7:0] == `SFM_A_FPR_HI)
        hrdata <= fpr_r[63:32];
      else if (haddr[7:0] == `SFM_A_CR)
        hrdata <= cr_r;
      else if (haddr[7:0] == `SFM_A_FP_STATUS_CONTROL_REGISTER)
        hrdata <= fp_r;
      else if (haddr[7:0] == `SFM_A_STAT)
        hrdata <= {28'h000_0000, stat_r};
      else if (haddr[7:0] == `SFM_A_MASK)
        hrdata <= {28'h000_0000, mask_r};
      else if (haddr[7:0] == `SFM_A_CNT)
        hrdata <= cnt_r;
      else
        hrdata <= 32'h0000_0000;
    end
  end

  // Operand staging for software-issued instructions
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      gpr_r <= 32'h0000_0000;
      fpr_r <= 64'h0000_0000_0000_0000;
      insn_r <= 32'h0000_0000;
      mask_r <= '0;
    end
    else if (ap_wr_r)
    begin
      if (ap_addr_r == `SFM_A_GPR)
        gpr_r <= hwdata;
      else if (ap_addr_r == `SFM_A_FPR_LO)
        fpr_r[31:0] <= hwdata;
      else if (ap_addr_r == `SFM_A_FPR_HI)
        fpr_r[63:32] <= hwdata;
      else if (ap_addr_r == `SFM_A_INSN)
        insn_r <= hwdata;
      else if (ap_addr_r == `SFM_A_MASK)
        mask_r <= hwdata[`SFM_NEV-1:0];
    end
  end

  // A write to the instruction register issues it next cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      bus_issue <= 1'b0;
    else
      bus_issue <= ap_wr_r && ap_addr_r == `SFM_A_INSN;
  end

  // ***********************************************
  // Decode and execute
  // ***********************************************

  // Pipeline issue wins; a bus issue in the same cycle is dropped
  assign issue_ready = 1'b1;
  wire go = issue_valid || bus_issue;
  wire [31:0] x_insn = issue_valid ? issue_insn : insn_r;
  wire [31:0] x_gpr = issue_valid ? issue_gpr : gpr_r;
  wire [63:0] x_fpr = issue_valid ? issue_fpr : fpr_r;

  sfm_pkg::sfm_dec_s dec;

  sfm_decode u_dec (
    .insn(x_insn),
    .dec(dec)
  );

  logic [31:0] fp_nxt;
  logic [31:0] cr_nxt;
  logic lock_hit;

  always_comb
  begin
    fp_nxt = fp_r;
    lock_hit = 1'b0;
    if (go)
    begin
      if (dec.op == sfm_pkg::SFM_CLR || dec.op == sfm_pkg::SFM_SET)
      begin
        if (dec.reg_idx == `SFM_FP_LOCK_A || dec.reg_idx == `SFM_FP_LOCK_B)
          lock_hit = 1'b1; // RL10
        else
          fp_nxt[be_pos(dec.reg_idx)] = dec.op == sfm_pkg::SFM_SET; // RL7 RL9
      end
      else if (dec.op == sfm_pkg::SFM_FSF)
      begin
        fp_nxt = merge(fp_r, x_fpr[31:0], dec.fp_field_mask); // RL14 RL15
      end
    end
  end

  always_comb
  begin
    cr_nxt = cr_r;
    if (go && dec.op == sfm_pkg::SFM_CRF)
    begin
      cr_nxt = merge(cr_r, x_gpr, dec.cond_field_mask); // RL2 RL3
    end
    else if (go && dec.record_bit && dec.op != sfm_pkg::SFM_NONE)
    begin
      cr_nxt[be_pos(5'd4 * 5'(`SFM_CR_FIELD1)) -: 4] = {
        fp_nxt[be_pos(5'(`SFM_FP_FX))],
        fp_nxt[be_pos(5'(`SFM_FP_FEX))],
        fp_nxt[be_pos(5'(`SFM_FP_VX))],
        fp_nxt[be_pos(5'(`SFM_FP_OX))]}; // RL11
    end
  end

  // No fixed-point exception register exists here, so it is never touched
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cr_r <= `SFM_CR_RST;
      fp_r <= `SFM_FP_RST;
    end
    else
    begin
      cr_r <= cr_nxt; // RL4 RL12
      fp_r <= fp_nxt;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      done <= 1'b0;
    else
      done <= go && dec.op != sfm_pkg::SFM_NONE;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      cnt_r <= 32'h0000_0000;
    else if (go && dec.op != sfm_pkg::SFM_NONE)
      cnt_r <= cnt_r + 32'h0000_0001;
  end

  assign arch.condition_register = cr_r;
  assign arch.fp_status_control_register = fp_r;

  // ***********************************************
  // Interrupts
  // ***********************************************

  logic [`SFM_NEV-1:0] ev;

  always_comb
  begin
    ev = '0;
    ev[`SFM_EV_CRF] = go && dec.op == sfm_pkg::SFM_CRF;
    ev[`SFM_EV_FPS] = go && dec.op != sfm_pkg::SFM_NONE
                      && dec.op != sfm_pkg::SFM_CRF;
    ev[`SFM_EV_BAD] = go && dec.op == sfm_pkg::SFM_NONE;
    ev[`SFM_EV_LOCK] = lock_hit;
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      stat_r <= '0;
    else if (ap_wr_r && ap_addr_r == `SFM_A_STAT)
      stat_r <= (stat_r & ~hwdata[`SFM_NEV-1:0]) | ev;
    else
      stat_r <= stat_r | ev;
  end

  assign irq = |(stat_r & mask_r);

endmodule // sfm_unit

// >>> verif/sfm_unit_props.sv
`timescale 1ns/1ps
module sfm_unit_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic issue_valid,
  input wire logic [31:0] issue_insn,
  input wire logic [31:0] issue_gpr,
  input wire logic [63:0] issue_fpr,
  input wire logic done,
  input wire sfm_pkg::sfm_arch_s arch
);
  logic pv, crf, clr, st, fsf, fpo, lk;
  logic [31:0] pi, pg, pf, pc, pp, cr, fp, mc, mf, b;
  function automatic logic [31:0] nib(input logic [7:0] m);
    for (int i = 0; i < 8; i++)
      nib[4*i+:4] = {4{m[i]}};
  endfunction
  // Snapshot of the issue edge, so each check can compare the new state with the issued word, operands and old state
  always_ff @(posedge clock)
  begin
    pv <= issue_valid;
    pi <= issue_insn;
    pg <= issue_gpr;
    pf <= issue_fpr[31:0];
    pc <= cr;
    pp <= fp;
  end
  assign cr = arch.condition_register;
  assign fp = arch.fp_status_control_register;
  assign crf = pv && pi[31:26] == 6'h1f && pi[10:1] == 10'h090;
  assign clr = pv && pi[31:26] == 6'h3f && pi[10:1] == 10'h046;
  assign st = pv && pi[31:26] == 6'h3f && pi[10:1] == 10'h026;
  assign fsf = pv && pi[31:26] == 6'h3f && pi[10:1] == 10'h303;
  assign fpo = clr || st || fsf;
  assign lk = pi[25:21] == 5'h01 || pi[25:21] == 5'h02;
  assign mc = nib(pi[19:12]);
  assign mf = nib(pi[24:17]);
  assign b = 32'h8000_0000 >> pi[25:21];
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  AST_DONE: assert property (pv |-> done == (crf || fpo))
    else $error("done does not match decode");
  AST_CRF_COPY: assert property (crf |-> (cr & mc) == (pg & mc))
    else $error("masked field not copied");
  AST_CRF_KEEP: assert property (crf |-> (cr & ~mc) == (pc & ~mc))
    else $error("unmasked field changed");
  AST_CLR: assert property (clr && !lk |-> fp == (pp & ~b))
    else $error("bit clear wrong");
  AST_SET: assert property (st && !lk |-> fp == (pp | b))
    else $error("bit set wrong");
  AST_LOCK: assert property ((clr || st) && lk |-> $stable(fp))
    else $error("locked bit changed");
  AST_FSF: assert property (fsf |-> fp == (pp & ~mf | pf & mf))
    else $error("field move wrong");
  AST_REC: assert property (fpo && pi[0] |-> cr[27:24] == fp[31:28])
    else $error("record copy wrong");
  AST_NOREC: assert property (fpo && !pi[0] |-> cr == pc)
    else $error("condition changed");
  cover property (crf && pi[19:12] == 8'ha5);
  cover property ((clr || st) && lk);
  cover property (fsf && pi[0]);
endmodule // sfm_unit_props

bind sfm_unit sfm_unit_props u_props (.clock, .rst, .issue_valid,
  .issue_insn, .issue_gpr, .issue_fpr, .done, .arch);

// >>> verif/sfm_pipe.sv
`timescale 1ns/1ps
module sfm_pipe (
  input wire logic clock,
  output logic valid,
  output logic [31:0] insn,
  output logic [31:0] gpr,
  output logic [63:0] fpr
);
  initial {valid, insn, gpr, fpr} = '0;
  // Calls in a row issue back to back
  task automatic issue(input logic [31:0] w, g, input logic [63:0] f);
    @(posedge clock);
    valid <= 1'b1;
    insn <= w;
    gpr <= g;
    fpr <= f;
  endtask
  // Released operands show the inverse of their last value
  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge clock);
      valid <= 1'b0;
      insn <= ~insn;
      gpr <= ~gpr;
      fpr <= ~fpr;
    end
  endtask
endmodule // sfm_pipe

// >>> verif/tb_status_field_move_unit.sv
`timescale 1ns/1ps
module tb_status_field_move_unit;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic iv, done, irq, hsel, hwrite, hrdy, hresp, rdy;
  logic [31:0] iw, ig, haddr, hwdata, hrdata, rd, ecr, efp;
  logic [63:0] ifp;
  logic [1:0] htrans;
  sfm_pkg::sfm_arch_s arch;
  int fail_count = 0;
  int num_checks = 0;
  always #5 clock = ~clock;
  sfm_pipe u_pipe (.clock(clock), .valid(iv), .insn(iw), .gpr(ig),
    .fpr(ifp));
  sfm_unit u_dut (.clock(clock), .rst(rst), .issue_valid(iv),
    .issue_insn(iw), .issue_gpr(ig), .issue_fpr(ifp), .issue_ready(rdy),
    .done(done), .arch(arch), .irq(irq), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp));
  function automatic logic [31:0] nib(input logic [7:0] m);
    for (int i = 0; i < 8; i++)
      nib[4*i+:4] = {4{m[i]}};
  endfunction
  function automatic logic [31:0] crfw(input logic [7:0] m);
    return {6'h1f, 5'h05, 1'b0, m, 1'b0, 10'h090, 1'b0};
  endfunction
  function automatic logic [31:0] fpw(input logic [14:0] f,
    input logic [9:0] x, input logic r);
    return {6'h3f, f, x, r};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude();
    if (fail_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  task automatic run(input logic [31:0] w, g, input logic [63:0] f,
    input logic d);
    u_pipe.issue(w, g, f);
    u_pipe.idle(1);
    #1;
    chk("done", {31'h0, d}, {31'h0, done});
  endtask
  task automatic t_crf();
    logic [7:0] m;
    logic [31:0] g;
    chk("reset", 32'h0, arch[63:32] | arch[31:0]);
    for (int i = 0; i < 9; i++)
    begin
      m = i < 8 ? 8'h01 << i : 8'ha5;
      g = 32'h1357_9bdf << i;
      ecr = ecr & ~nib(m) | g & nib(m);
      if (i < 8)
        u_pipe.issue(crfw(m), g, 64'h0);
      else
        run(crfw(m), g, 64'h0, 1'b1);
    end
    chk("cr", ecr, arch[63:32]);
    chk("fp", efp, arch[31:0]);
  endtask
  task automatic t_fsf();
    efp = 32'h6a5c_3e81;
    run(fpw({1'b0, 8'hff, 1'b0, 5'h05}, 10'h303, 1'b0), 32'h0,
      64'hffff_ffff_6a5c_3e81, 1'b1);
    chk("fp_all", efp, arch[31:0]);
    chk("cr_norec", ecr, arch[63:32]);
    efp = 32'h232c_3e81;
    ecr[27:24] = 4'h2;
    run(fpw({1'b0, 8'he0, 1'b0, 5'h05}, 10'h303, 1'b1), 32'h0,
      64'h5555_aaaa_2320_0000, 1'b1);
    chk("fp_three", efp, arch[31:0]);
    chk("cr_rec", ecr, arch[63:32]);
  endtask
  task automatic t_bits();
    logic [4:0] bt [6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h1f};
    logic [31:0] b;
    foreach (bt[i])
    begin
      b = (bt[i] == 5'h01 || bt[i] == 5'h02) ? 32'h0 : 32'h8000_0000 >> bt[i];
      efp = efp | b;
      ecr[27:24] = efp[31:28];
      run(fpw({bt[i], 10'h000}, 10'h026, 1'b1), 32'h0, 64'h0, 1'b1);
      chk("fp_set", efp, arch[31:0]);
      chk("cr_rec", ecr, arch[63:32]);
      efp = efp & ~b;
      run(fpw({bt[i], 10'h000}, 10'h046, 1'b0), 32'h0, 64'h0, 1'b1);
      chk("fp_clr", efp, arch[31:0]);
      chk("cr_keep", ecr, arch[63:32]);
    end
  endtask
  task automatic t_bus();
    bus(1'b0, 32'h0000_0040, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, 32'h0000_0004, 32'h89ab_cdef);
    bus(1'b1, 32'h0000_0000, crfw(8'h0f));
    for (int k = 0; k < 8 && done !== 1'b1; k++)
    begin
      @(posedge clock);
      #1;
    end
    chk("done_bus", 32'h1, {31'h0, done});
    ecr = ecr & 32'hffff_0000 | 32'h0000_cdef;
    bus(1'b0, 32'h0000_0010, 32'h0);
    chk("cr_bus", ecr, rd);
    bus(1'b0, 32'h0000_0014, 32'h0);
    chk("fp_bus", efp, rd);
    run(32'h0, 32'h0, 64'h0, 1'b0);
    chk("irq_masked", 32'h0, {31'h0, irq});
    bus(1'b1, 32'h0000_001c, 32'h0000_0004);
    #1;
    chk("irq_on", 32'h1, {31'h0, irq});
    bus(1'b1, 32'h0000_0018, 32'h0000_0004);
    #1;
    chk("irq_off", 32'h0, {31'h0, irq});
    bus(1'b0, 32'h0000_0018, 32'h0);
    chk("status", 32'h0000_000b, rd);
    bus(1'b0, 32'h0000_0020, 32'h0);
    chk("count", 32'h0000_0018, rd);
    bus(1'b0, 32'h0000_0004, 32'h0);
    chk("gpr_back", 32'h89ab_cdef, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("issue_ready", 32'h1, {31'h0, rdy});
  endtask
  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata, ecr, efp} = '0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_crf();
    t_fsf();
    t_bits();
    t_bus();
    conclude();
  end
  initial
  begin
    #20000;
    fail_count++;
    conclude();
  end
endmodule // tb_status_field_move_unit
